// file: src/psm_spline_motion.sv
// Purpose: buffered spline position motion unit
// Assumes: object requests one per cycle, sync inputs
// Notes: demand words leave through a two-entry buffer
// Summary of operation
// - mode selected by mode code seven
// - each point is one 64-bit FIFO record
// - position low, velocity middle, time top byte
// - sub-machine lives only in operation enabled
// - inactive state buffers points, axis still
// - active state buffers and moves axis
// - entering mode empties the buffer
// - other mode leaves sub-machine, nothing else
// - enable bit written with halt clear and no error makes state active
// - enable cleared or zero time ends activity
// - halt bit stops axis with profile deceleration
// - buffer config object reports state, clears
// - target reached after window dwell time
// - profile velocity/acceleration exceed sets warnings
// - maximal limits exceed sets error, fault
// - underflow and overflow warning levels configurable
// - buffer status word readable in sub one
// - trajectory output is the position demand
// - one polynomial evaluation per 1 kHz sample
// - buffer holds 64 records
// - segment times 1 to 255 ms, unequal
// - active with under two records is underflow
`timescale 1ns/100ps
`default_nettype none
`include "psm_regs.svh"
module psm_spline_motion #(
	parameter int SAMPLE_CYC = `PSM_SAMPLE_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic op_enabled,
	input wire psm_pkg::psm_req_type req,
	output logic ack,
	output logic abort,
	output logic [63:0] rdata,
	input wire logic signed [31:0] actual_pos,
	output logic dem_valid,
	input wire logic dem_ready,
	output logic signed [31:0] dem_pos,
	output logic fault_reaction
);
	import psm_pkg::*;
	////////////////////////////////////////////////////////////////
	// State
	psm_ip_state_type st, next_st; // Sub-machine state
	logic [15:0] cmd, next_cmd; // Drive command word
	logic [7:0] mode, next_mode; // Selected mode
	logic [5:0] rp, next_rp, wp, next_wp; // FIFO pointers
	logic [6:0] cnt, next_cnt; // FIFO fill
	logic signed [31:0] p0, next_p0; // Segment start position
	logic signed [23:0] v0, next_v0; // Segment start velocity
	logic [7:0] u, next_u; // Elapsed ms in segment
	logic signed [31:0] demand, next_demand; // Position demand
	logic signed [31:0] pvel, next_pvel; // Last step velocity
	logic signed [31:0] hvel, next_hvel; // Halt ramp velocity
	logic [3:0] err, next_err; // Uf, ov, vel, acc errors
	logic [1:0] warn, next_warn; // Vel, acc warnings
	logic [15:0] wcnt, next_wcnt; // Window dwell count
	logic reached, next_reached; // Target reached
	logic [16:0] div, next_div; // Sample divider
	logic pend, next_pend; // Sample waiting for space
	logic arm, next_arm; // Start armed by a command write
	logic [6:0] uflvl, next_uflvl, oflvl, next_oflvl; // Warning levels
	logic signed [31:0] lmin, next_lmin, lmax, next_lmax; // Limits
	logic [31:0] win, next_win, cpvel, next_cpvel, cpacc, next_cpacc;
	logic [31:0] cmvel, next_cmvel, cmacc, next_cmacc, cpdec, next_cpdec;
	logic [15:0] wtime, next_wtime; // Dwell time in ms
	logic next_ack, next_abort; // Object answer
	logic [63:0] next_rdata; // Read value
	psm_rec_type mem [0:63]; // Reference point storage
	psm_rec_type b0, next_b0, b1, next_b1; // Demand buffer words
	logic [1:0] bcnt, next_bcnt; // Demand buffer fill
	// Combinational helpers
	psm_rec_type head; // Oldest record, segment end
	logic tick, step, space, sel, push, pop, clr, wr_rec, full, hit;
	logic signed [63:0] dp, c2, c3, tt, t2, t3, uu, u2, u3, pv, v0e, v1e;
	logic signed [31:0] cand, vel, acc, tgt, dif;
	logic [31:0] av, aa;
	logic [15:0] bstat;
	logic [23:0] key;
	////////////////////////////////////////////////////////////////
	// Sample divider, object decode and FIFO head
	assign tick = div == 17'h00000;
	assign head = mem[rp];
	assign sel = (mode == `PSM_MODE_CODE) && op_enabled;
	assign full = cnt == `PSM_DEPTH;
	assign key = {req.index, req.sub};
	assign space = bcnt != 2'h2 || (dem_valid && dem_ready);
	assign step = (tick || pend) && space;
	assign wr_rec = req.wr && req.index == `PSM_IX_RECORD && sel;
	assign push = wr_rec && !full;
	////////////////////////////////////////////////////////////////
	// Cubic segment from start point to head record
	always_comb begin
		tt = (head.seg_ms == 8'h00) ? 64'sh1 : 64'(head.seg_ms);
		t2 = tt * tt;
		t3 = t2 * tt;
		uu = 64'(u) + 64'sh1;
		u2 = uu * uu;
		u3 = u2 * uu;
		v0e = 64'(v0);
		v1e = 64'(head.vel);
		dp = 64'(head.pos) - 64'(p0);
		c2 = 64'sh3 * dp - tt * (v1e + 64'sh2 * v0e);
		c3 = tt * (v0e + v1e) - 64'sh2 * dp;
		pv = 64'(p0) + v0e * uu + (c2 * u2) / t2 + (c3 * u3) / t3;
		cand = pv[31:0];
		if (cand < lmin) begin
			cand = lmin;
		end else if (cand > lmax) begin
			cand = lmax;
		end
		vel = cand - demand;
		acc = vel - pvel;
		av = vel[31] ? 32'(-vel) : 32'(vel);
		aa = acc[31] ? 32'(-acc) : 32'(acc);
	end
	////////////////////////////////////////////////////////////////
	// Sub-machine, FIFO control, trajectory and flags
	always_comb begin
		next_st = st;
		next_rp = rp;
		next_wp = wp;
		next_p0 = p0;
		next_v0 = v0;
		next_u = u;
		next_demand = demand;
		next_pvel = pvel;
		next_hvel = hvel;
		next_err = err;
		next_warn = warn;
		next_arm = arm;
		next_pend = (tick || pend) && !space;
		next_div = (div == 17'(SAMPLE_CYC - 1)) ? 17'h00000 : div + 17'h00001;
		pop = 1'b0;
		clr = req.wr && req.index == `PSM_IX_BUFCFG;
		if (!sel) begin
			next_st = PSM_OFF;
		end else if (st == PSM_OFF) begin
			next_st = PSM_IDLE;
			clr = 1'b1;
		end
		if (clr) begin
			next_err = 4'h0;
			next_warn = 2'h0;
		end
		if (st == PSM_IDLE && sel && arm && cmd[`PSM_CMD_EN] && !cmd[`PSM_CMD_HALT]
			&& err == 4'h0) begin
			next_st = PSM_RUN;
			next_arm = 1'b0;
			next_p0 = demand;
			next_v0 = 24'sh000000;
			next_u = 8'h00;
		end
		// Only a fresh command write restarts; a zero-time stop stays stopped
		if (!sel) begin
			next_arm = 1'b0;
		end
		if (req.wr && key == {`PSM_IX_CMD, 8'h00}) begin
			next_arm = 1'b1;
		end
		if (st == PSM_RUN && sel) begin
			if (cmd[`PSM_CMD_HALT]) begin
				if (step) begin
					next_demand = demand + hvel;
					next_pvel = hvel;
					if (32'(hvel[31] ? -hvel : hvel) <= cpdec) begin
						next_hvel = 32'sh00000000;
					end else begin
						next_hvel = hvel[31] ? hvel + $signed(cpdec) : hvel - $signed(cpdec);
					end
					if (hvel == 32'sh00000000) begin
						next_st = PSM_IDLE;
					end
				end
			end else if (!cmd[`PSM_CMD_EN]) begin
				next_st = PSM_IDLE;
			end else if (step) begin
				if (cnt != 7'h00 && head.seg_ms == 8'h00) begin
					pop = 1'b1;
					next_st = PSM_IDLE;
				end else if (cnt < 7'h02) begin
					next_err[0] = 1'b1;
					next_st = PSM_IDLE;
				end else begin
					next_demand = cand;
					next_pvel = vel;
					next_hvel = vel;
					if (av > cpvel) begin
						next_warn[0] = 1'b1;
					end
					if (aa > cpacc) begin
						next_warn[1] = 1'b1;
					end
					if (av > cmvel || aa > cmacc) begin
						next_err[2] = av > cmvel;
						next_err[3] = aa > cmacc;
						next_st = PSM_IDLE;
					end
					if (next_u + 8'h01 == head.seg_ms) begin
						pop = 1'b1;
						next_p0 = head.pos;
						next_v0 = head.vel;
						next_u = 8'h00;
					end else begin
						next_u = u + 8'h01;
					end
				end
			end
		end
		if (wr_rec && full) begin
			next_err[1] = 1'b1;
			next_st = PSM_IDLE;
		end
		if (clr) begin
			next_rp = 6'h00;
			next_wp = push ? 6'h01 : 6'h00;
			next_cnt = push ? 7'h01 : 7'h00;
		end else begin
			next_rp = pop ? rp + 6'h01 : rp;
			next_wp = push ? wp + 6'h01 : wp;
			next_cnt = cnt + (push ? 7'h01 : 7'h00) - (pop ? 7'h01 : 7'h00);
		end
		// Target reached dwell
		tgt = (st == PSM_RUN && cnt != 7'h00) ? head.pos : p0;
		dif = actual_pos - tgt;
		next_wcnt = wcnt;
		next_reached = reached;
		if (cmd[`PSM_CMD_HALT]) begin
			next_reached = hvel == 32'sh00000000;
		end else if (32'(dif[31] ? -dif : dif) > win) begin
			next_wcnt = 16'h0000;
			next_reached = 1'b0;
		end else if (tick) begin
			next_wcnt = (wcnt == 16'hFFFF) ? wcnt : wcnt + 16'h0001;
			next_reached = wcnt >= wtime;
		end
		// Demand output buffer
		next_b0 = b0;
		next_b1 = b1;
		next_bcnt = bcnt;
		if (dem_valid && dem_ready) begin
			next_b0 = b1;
			next_bcnt = bcnt - 2'h1;
		end
		// Demand words flow on every step while the sub-machine is active, moving or not
		if (step && st == PSM_RUN) begin
			if (next_bcnt == 2'h0) begin
				next_b0.pos = next_demand;
			end else begin
				next_b1.pos = next_demand;
			end
			next_bcnt = next_bcnt + 2'h1;
		end
	end
	////////////////////////////////////////////////////////////////
	// Object access: writes and registered reads
	always_comb begin
		bstat = {st == PSM_RUN, sel, 2'b00, err, 4'h0, warn,
			cnt >= oflvl, cnt < uflvl};
		next_cmd = cmd;
		next_mode = mode;
		next_uflvl = uflvl;
		next_oflvl = oflvl;
		next_lmin = lmin;
		next_lmax = lmax;
		next_win = win;
		next_wtime = wtime;
		next_cpvel = cpvel;
		next_cpacc = cpacc;
		next_cpdec = cpdec;
		next_cmvel = cmvel;
		next_cmacc = cmacc;
		next_rdata = rdata;
		hit = 1'b1;
		case (key)
			{`PSM_IX_CMD, 8'h00}: next_rdata = 64'(cmd);
			{`PSM_IX_STW, 8'h00}: next_rdata = 64'({st == PSM_RUN, 1'b0, reached, 10'h000});
			{`PSM_IX_MODE, 8'h00}: next_rdata = 64'(mode);
			{`PSM_IX_DEMAND, 8'h00}: next_rdata = 64'(demand);
			{`PSM_IX_RECORD, 8'h00}: hit = !req.rd && (sel || !req.wr);
			{`PSM_IX_ISTAT, `PSM_SUB_BSTAT}: next_rdata = 64'(bstat);
			{`PSM_IX_ISTAT, `PSM_SUB_UFLVL}: next_rdata = 64'(uflvl);
			{`PSM_IX_ISTAT, `PSM_SUB_OFLVL}: next_rdata = 64'(oflvl);
			{`PSM_IX_BUFCFG, 8'h00}: next_rdata = {32'(`PSM_DEPTH), 32'(cnt)};
			{`PSM_IX_LIMIT, `PSM_SUB_LMIN}: next_rdata = 64'(lmin);
			{`PSM_IX_LIMIT, `PSM_SUB_LMAX}: next_rdata = 64'(lmax);
			{`PSM_IX_WIN, 8'h00}: next_rdata = 64'(win);
			{`PSM_IX_WTIME, 8'h00}: next_rdata = 64'(wtime);
			{`PSM_IX_PVEL, 8'h00}: next_rdata = 64'(cpvel);
			{`PSM_IX_PACC, 8'h00}: next_rdata = 64'(cpacc);
			{`PSM_IX_PDEC, 8'h00}: next_rdata = 64'(cpdec);
			{`PSM_IX_MVEL, 8'h00}: next_rdata = 64'(cmvel);
			{`PSM_IX_MACC, 8'h00}: next_rdata = 64'(cmacc);
			default: hit = 1'b0;
		endcase
		if (!req.rd) begin
			next_rdata = rdata;
		end
		if (req.wr && (key == {`PSM_IX_STW, 8'h00} || key == {`PSM_IX_DEMAND, 8'h00}
			|| key == {`PSM_IX_ISTAT, `PSM_SUB_BSTAT})) begin
			hit = 1'b0;
		end
		if (req.wr && hit) begin
			case (key)
				{`PSM_IX_CMD, 8'h00}: next_cmd = req.data[15:0];
				{`PSM_IX_MODE, 8'h00}: next_mode = req.data[7:0];
				{`PSM_IX_ISTAT, `PSM_SUB_UFLVL}: next_uflvl = req.data[6:0];
				{`PSM_IX_ISTAT, `PSM_SUB_OFLVL}: next_oflvl = req.data[6:0];
				{`PSM_IX_LIMIT, `PSM_SUB_LMIN}: next_lmin = req.data[31:0];
				{`PSM_IX_LIMIT, `PSM_SUB_LMAX}: next_lmax = req.data[31:0];
				{`PSM_IX_WIN, 8'h00}: next_win = req.data[31:0];
				{`PSM_IX_WTIME, 8'h00}: next_wtime = req.data[15:0];
				{`PSM_IX_PVEL, 8'h00}: next_cpvel = req.data[31:0];
				{`PSM_IX_PACC, 8'h00}: next_cpacc = req.data[31:0];
				{`PSM_IX_PDEC, 8'h00}: next_cpdec = req.data[31:0];
				{`PSM_IX_MVEL, 8'h00}: next_cmvel = req.data[31:0];
				{`PSM_IX_MACC, 8'h00}: next_cmacc = req.data[31:0];
				default: next_cmd = cmd;
			endcase
		end
		next_ack = req.wr || req.rd;
		next_abort = (req.wr || req.rd) && !hit;
	end
	////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= PSM_OFF;
			{cmd, mode, rp, wp, cnt, u} <= '0;
			{p0, v0, demand, pvel, hvel, err, warn} <= '0;
			{wcnt, reached, div, pend, b0, b1, bcnt} <= '0;
			arm <= 1'b0;
			uflvl <= `PSM_UFLVL_RST;
			oflvl <= `PSM_OFLVL_RST;
			lmin <= 32'sh80000000;
			lmax <= 32'sh7FFFFFFF;
			{win, wtime, cpvel, cpacc, cpdec} <= '0;
			cmvel <= 32'hFFFFFFFF;
			cmacc <= 32'hFFFFFFFF;
			{ack, abort, rdata} <= '0;
		end else begin
			st <= next_st;
			{cmd, mode, rp, wp, cnt, u} <= {next_cmd, next_mode, next_rp, next_wp, next_cnt, next_u};
			{p0, v0, demand, pvel, hvel} <= {next_p0, next_v0, next_demand, next_pvel, next_hvel};
			{err, warn, wcnt, reached} <= {next_err, next_warn, next_wcnt, next_reached};
			{div, pend, b0, b1, bcnt} <= {next_div, next_pend, next_b0, next_b1, next_bcnt};
			arm <= next_arm;
			{uflvl, oflvl, lmin, lmax} <= {next_uflvl, next_oflvl, next_lmin, next_lmax};
			{win, wtime, cpvel, cpacc} <= {next_win, next_wtime, next_cpvel, next_cpacc};
			{cpdec, cmvel, cmacc} <= {next_cpdec, next_cmvel, next_cmacc};
			{ack, abort, rdata} <= {next_ack, next_abort, next_rdata};
		end
	end
	// Record storage, written at the push slot
	always_ff @(posedge clk) begin
		if (push) begin
			mem[clr ? 6'h00 : wp] <= req.data;
		end
	end
	assign dem_valid = bcnt != 2'h0;
	assign dem_pos = b0.pos;
	assign fault_reaction = err != 4'h0;
	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_FULL_DROP: assert property (wr_rec && full |=> err[1] && cnt == `PSM_DEPTH)
		else $error("full buffer write not flagged");
	AST_ENTRY_CLEAR: assert property (st == PSM_OFF && sel |=> cnt <= 7'h01)
		else $error("buffer not emptied on entry");
	AST_OFF_OUTSIDE: assert property (!op_enabled |=> st == PSM_OFF)
		else $error("sub-machine active outside operation enabled");
	AST_IDLE_STILL: assert property (
		st == PSM_IDLE && $past(st) == PSM_IDLE |-> $stable(demand))
		else $error("axis moved while inactive");
	AST_DISABLE: assert property (st == PSM_RUN && !cmd[`PSM_CMD_EN]
		&& !cmd[`PSM_CMD_HALT] |=> st != PSM_RUN)
		else $error("enable clear did not end activity");
	AST_ENABLE: assert property (st == PSM_IDLE && sel && arm && cmd[`PSM_CMD_EN]
		&& !cmd[`PSM_CMD_HALT] && err == 4'h0 && !(wr_rec && full) |=> st == PSM_RUN)
		else $error("enable did not start activity");
	AST_ERR_STOP: assert property (err != 4'h0 |-> fault_reaction && st != PSM_RUN)
		else $error("error without fault or stop");
	AST_LIMITS: assert property (st == PSM_RUN && !cmd[`PSM_CMD_HALT]
		&& $changed(demand) |-> demand >= lmin && demand <= lmax)
		else $error("demand outside limits");
	AST_DEPTH: assert property (cnt <= `PSM_DEPTH)
		else $error("fill above depth");
	AST_HOLD: assert property (dem_valid && !dem_ready
		|=> dem_valid && dem_pos == $past(dem_pos))
		else $error("demand word lost under stall");
	AST_TICK: assert property (tick |=> !tick [*8])
		else $error("sample tick too frequent");
endmodule : psm_spline_motion
`default_nettype wire

// file: src/psm_regs.svh
// Purpose: object indices, bit positions, reset values and timing counts
// Assumes: 100 MHz system clock, 1 kHz control sample
// Notes: object reads and writes use index plus sub-entry
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH
// Object indices
`define PSM_IX_CMD 16'h6040
`define PSM_IX_STW 16'h6041
`define PSM_IX_MODE 16'h6060
`define PSM_IX_DEMAND 16'h6062
`define PSM_IX_RECORD 16'h20C1
`define PSM_IX_ISTAT 16'h20C4
`define PSM_IX_BUFCFG 16'h60C4
`define PSM_IX_LIMIT 16'h607D
`define PSM_IX_WIN 16'h6067
`define PSM_IX_WTIME 16'h6068
`define PSM_IX_PVEL 16'h6081
`define PSM_IX_PACC 16'h6083
`define PSM_IX_PDEC 16'h6084
`define PSM_IX_MVEL 16'h607F
`define PSM_IX_MACC 16'h60C5
// Sub-entries
`define PSM_SUB_BSTAT 8'h01
`define PSM_SUB_UFLVL 8'h02
`define PSM_SUB_OFLVL 8'h03
`define PSM_SUB_LMIN 8'h01
`define PSM_SUB_LMAX 8'h02
// Mode code and command bits
`define PSM_MODE_CODE 8'h07
`define PSM_CMD_EN 4
`define PSM_CMD_HALT 8
`define PSM_STW_REACHED 10
`define PSM_STW_RUNNING 12
// Buffer
`define PSM_DEPTH 7'h40
`define PSM_UFLVL_RST 7'h04
`define PSM_OFLVL_RST 7'h3C
// Timing
`define PSM_CLK_NS 10
`define PSM_SAMPLE_NS 1000000
`define PSM_SAMPLE_CYC (`PSM_SAMPLE_NS / `PSM_CLK_NS)
`endif

// file: src/psm_pkg.sv
// Purpose: shared types of the spline motion block
// Assumes: nothing
// Notes: record layout is time in the top byte, position at the bottom
package psm_pkg;
	// One reference point, 64 bits
	typedef struct packed {
		logic [7:0] seg_ms;
		logic signed [23:0] vel;
		logic signed [31:0] pos;
	} psm_rec_type;
	// One object access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] index;
		logic [7:0] sub;
		logic [63:0] data;
	} psm_req_type;
	// Interpolation sub-machine states
	typedef enum logic [1:0] {PSM_OFF, PSM_IDLE, PSM_RUN} psm_ip_state_type;
endpackage : psm_pkg

// file: sim/psm_planner.sv
// Purpose: trajectory planner side of the object bus
// Assumes: one access at a time, answer one clock after the request edge
// Notes: tasks are called from the testbench
`timescale 1ns/100ps
`default_nettype none
module psm_planner (
	input wire logic clk,
	output psm_pkg::psm_req_type req,
	input wire logic ack,
	input wire logic abort,
	input wire logic [63:0] rdata
);
	import psm_pkg::*;
	logic got_ack; // Last answer seen
	logic got_abort;
	logic [63:0] got_data;
	initial begin
		req = '0;
	end
	//////////////////////////////////////////////////////////////////////
	// One access: pulse on one edge, answer taken after the next edge
	task automatic access(input logic wr, input logic [15:0] ix, input logic [7:0] sb,
		input logic [63:0] d);
		@(posedge clk);
		req <= '{wr: wr, rd: !wr, index: ix, sub: sb, data: d};
		@(posedge clk);
		// Released fields show the inverse, never the last value
		req <= '{wr: 1'h0, rd: 1'h0, index: ~ix, sub: ~sb, data: ~d};
		#1;
		got_ack = ack;
		got_abort = abort;
		got_data = rdata;
	endtask : access
	// Packs one point: time on top, velocity in the middle, position low
	task automatic send_point(input logic signed [31:0] pos, input logic [7:0] ms);
		psm_rec_type rec;
		rec = '{seg_ms: ms, vel: 24'h0, pos: pos};
		access(1'h1, 16'h20C1, 8'h00, rec);
	endtask : send_point
endmodule : psm_planner
`default_nettype wire

// file: sim/testbench.sv
// Purpose: self-checking bench of the spline motion unit
// Assumes: short sample period, planner model drives the object bus
// Notes: table of object accesses first, then hand-written sequences
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import psm_pkg::*;
	// Object access with its expected answer
	typedef struct packed {
		logic wr;
		logic [15:0] ix;
		logic [7:0] sb;
		logic [63:0] d;
		logic ab;
		logic [63:0] rd;
	} psm_row_type;
	localparam int SAMP = 20; // Short sample period
	logic clk;
	logic arst_n;
	logic op_enabled;
	psm_req_type req;
	logic ack;
	logic abort;
	logic [63:0] rdata;
	logic signed [31:0] actual_pos;
	logic dem_valid;
	logic dem_ready;
	logic signed [31:0] dem_pos;
	logic fault_reaction;
	logic [63:0] v; // Last read value
	int error_cnt = 0;
	int check_count = 0;
	int cycle = 0;
	int taken = 0; // Demand words taken
	int n;
	psm_row_type rows [0:12];
	//////////////////////////////////////////////////////////////////////
	psm_spline_motion #(.SAMPLE_CYC(SAMP)) psm_spline_motion_i (.clk(clk), .arst_n(arst_n),
		.op_enabled(op_enabled), .req(req), .ack(ack), .abort(abort), .rdata(rdata),
		.actual_pos(actual_pos), .dem_valid(dem_valid), .dem_ready(dem_ready),
		.dem_pos(dem_pos), .fault_reaction(fault_reaction));
	psm_planner psm_planner_i (.clk(clk), .req(req), .ack(ack), .abort(abort),
		.rdata(rdata));
	//////////////////////////////////////////////////////////////////////
	// Clock of 10 ns
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Position loop stalls half the time; the axis follows the demand
	always @(posedge clk) begin
		cycle <= cycle + 1;
		dem_ready <= cycle[3];
		// The axis moves only to words actually taken
		if (dem_valid && dem_ready) begin
			taken <= taken + 1;
			actual_pos <= dem_pos;
		end
		if (cycle == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	//////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [63:0] d);
		psm_planner_i.access(1'h1, ix, sb, d);
	endtask : wr
	task automatic rd(input logic [15:0] ix, input logic [7:0] sb);
		psm_planner_i.access(1'h0, ix, sb, 64'h0);
		v = psm_planner_i.got_data;
	endtask : rd
	task automatic finish_test;
		$display("TB: %0d errors in %0d checks", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	//////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		arst_n = 1'h0;
		op_enabled = 1'h1;
		actual_pos = 32'h0;
		dem_ready = 1'h0;
		rows = '{
			'{1'h1, 16'h6060, 8'h00, 64'h7, 1'h0, 64'h0},
			'{1'h0, 16'h6060, 8'h00, 64'h0, 1'h0, 64'h7},
			'{1'h0, 16'h60C4, 8'h00, 64'h0, 1'h0, 64'h0000004000000000},
			'{1'h0, 16'h20C4, 8'h02, 64'h0, 1'h0, 64'h4},
			'{1'h0, 16'h20C4, 8'h03, 64'h0, 1'h0, 64'h3C},
			'{1'h1, 16'h20C4, 8'h02, 64'h6, 1'h0, 64'h0},
			'{1'h0, 16'h20C4, 8'h02, 64'h0, 1'h0, 64'h6},
			'{1'h0, 16'h20C4, 8'h01, 64'h0, 1'h0, 64'h4001},
			'{1'h0, 16'h20C1, 8'h00, 64'h0, 1'h1, 64'h0},
			'{1'h1, 16'h6041, 8'h00, 64'h1, 1'h1, 64'h0},
			'{1'h1, 16'h6062, 8'h00, 64'h1, 1'h1, 64'h0},
			'{1'h1, 16'h20C4, 8'h01, 64'h1, 1'h1, 64'h0},
			'{1'h0, 16'h1234, 8'h00, 64'h0, 1'h1, 64'h0}};
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		#1;
		check({ack, dem_valid, fault_reaction}, 3'h0);
		// Table of object accesses
		foreach (rows[i]) begin
			psm_planner_i.access(rows[i].wr, rows[i].ix, rows[i].sb, rows[i].d);
			check(psm_planner_i.got_ack, 1'h1);
			check(psm_planner_i.got_abort, rows[i].ab);
			if (!rows[i].wr && !rows[i].ab)
				check(psm_planner_i.got_data, rows[i].rd);
		end
		// Inactive: points are stored, the axis stays still
		repeat (3) psm_planner_i.send_point(32'h64, 8'h02);
		rd(16'h60C4, 8'h00);
		check(v, 64'h0000004000000003);
		repeat (3 * SAMP) @(posedge clk);
		#1;
		check(dem_valid, 1'h0);
		// Another mode leaves the buffer alone and refuses points
		wr(16'h6060, 8'h00, 64'h1);
		rd(16'h60C4, 8'h00);
		check(v[31:0], 32'h3);
		psm_planner_i.send_point(32'h64, 8'h02);
		check(psm_planner_i.got_abort, 1'h1);
		@(posedge clk);
		op_enabled <= 1'h0;
		wr(16'h6060, 8'h00, 64'h7);
		psm_planner_i.send_point(32'h64, 8'h02);
		check(psm_planner_i.got_abort, 1'h1);
		@(posedge clk);
		op_enabled <= 1'h1;
		repeat (2) @(posedge clk);
		rd(16'h60C4, 8'h00);
		check(v[31:0], 32'h0);
		// Halt holds the axis, enable alone starts it
		psm_planner_i.send_point(32'h3E8, 8'h04);
		psm_planner_i.send_point(32'h3E8, 8'h04);
		psm_planner_i.send_point(32'h0, 8'h00);
		wr(16'h6040, 8'h00, 64'h110);
		repeat (2 * SAMP) @(posedge clk);
		rd(16'h6041, 8'h00);
		check(v[12], 1'h0);
		wr(16'h6040, 8'h00, 64'h10);
		rd(16'h6041, 8'h00);
		check(v[12], 1'h1);
		n = 0;
		while (v[12] === 1'h1 && n < 2000) begin
			rd(16'h6041, 8'h00);
			n++;
		end
		// The zero-time point has already ended the run; disable clears the command
		wr(16'h6040, 8'h00, 64'h0);
		check(v[12], 1'h0);
		repeat (SAMP) @(posedge clk);
		rd(16'h6062, 8'h00);
		check(v[31:0], 32'h3E8);
		check(taken >= 8 && taken <= 9, 1'h1);
		rd(16'h6041, 8'h00);
		check(v[10], 1'h1);
		rd(16'h20C4, 8'h01);
		check({v[11:8], fault_reaction}, 5'h0);
		check(v[3:2], 2'h3);
		// A lone point while running underflows
		psm_planner_i.send_point(32'h3E8, 8'h04);
		wr(16'h6040, 8'h00, 64'h10);
		n = 0;
		while (fault_reaction !== 1'h1 && n < 4 * SAMP) begin
			@(posedge clk);
			n++;
		end
		rd(16'h20C4, 8'h01);
		check({v[8], fault_reaction}, 2'h3);
		wr(16'h6040, 8'h00, 64'h0);
		wr(16'h60C4, 8'h00, 64'h0);
		rd(16'h20C4, 8'h01);
		check({v[11:8], fault_reaction}, 5'h0);
		// Clamp at the upper software limit; the target then stays unreached
		wr(16'h607D, 8'h02, 64'h4B0);
		repeat (2) psm_planner_i.send_point(32'h7D0, 8'h04);
		psm_planner_i.send_point(32'h0, 8'h00);
		wr(16'h6040, 8'h00, 64'h10);
		repeat (12 * SAMP) @(posedge clk);
		rd(16'h6062, 8'h00);
		check(v[31:0], 32'h4B0);
		rd(16'h6041, 8'h00);
		check({v[12], v[10]}, 2'h0);
		// Fill to the brim, then one more
		for (int i = 0; i < 64; i++) psm_planner_i.send_point(i, 8'h01);
		rd(16'h60C4, 8'h00);
		check(v, 64'h0000004000000040);
		psm_planner_i.send_point(32'h0, 8'h01);
		check(psm_planner_i.got_abort, 1'h0);
		rd(16'h20C4, 8'h01);
		check({v[9], v[1], fault_reaction}, 3'h7);
		rd(16'h60C4, 8'h00);
		check(v[31:0], 32'h40);
		// Reset while idle with a full buffer and an error returns the defaults
		@(posedge clk);
		arst_n <= 1'h0;
		@(posedge clk);
		#1;
		check({ack, dem_valid, fault_reaction}, 3'h0);
		@(posedge clk);
		arst_n <= 1'h1;
		rd(16'h60C4, 8'h00);
		check(v, 64'h0000004000000000);
		rd(16'h6060, 8'h00);
		check(v, 64'h0);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
